// File: vbc_top.sv
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps

module vbc_top
    import vbc_pkg::*;
#(
    parameter logic [15:0] VCO_THRESH_LOW  = 16'h0100,
    parameter logic [15:0] VCO_THRESH_HIGH = 16'h0200
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        chip_enable_in,
    input  wire logic        mixer_select_in,
    input  wire logic        vco_above_in,
    input  wire logic        lock_detect_in,
    input  wire logic        pd_ref_in,
    output logic             irq,
    output logic [1:0]       osc_select,
    output logic [6:0]       band_trim,
    output logic [15:0]      target_n,
    output logic [2:0]       lo_div_code,
    output logic             loop_enable,
    output logic             mixer1_en,
    output logic             mixer2_en
);

    typedef struct packed {
        logic [4:0]       s1;
        logic [4:0]       s2;
        logic [4:0]       s3;
        vbc_state_type    state;
        logic             sw_mode;
        logic             mix_sel_sw;
        logic             full_duplex_select;
        logic [2:0]       lo_div;
        logic [15:0]      synth_bank_first;
        logic [15:0]      synth_bank_second;
        logic [7:0]       settle;
        vbc_readback_type rb;
        vbc_irq_type      status;
        vbc_irq_type      mask;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             irq;
        logic [1:0]       osc;
        logic [6:0]       band_trim;
        logic [15:0]      target_n;
        logic             loop_en;
        logic             mix1;
        logic             mix2;
    } vbc_top_reg_type;

    vbc_top_reg_type r;
    vbc_top_reg_type next_r;

    logic        en;
    logic        en_rise;
    logic        pd_tick;
    logic        mix_pin;
    logic        above;
    logic        lockd;
    logic        mixsel;
    logic [15:0] active_n;
    logic        setup;
    logic        access;
    logic        relock_req;
    logic        start;
    logic        search_start;
    logic [6:0]  search_trial;
    logic [6:0]  search_band;
    logic        search_done;
    vbc_irq_type events;

    function automatic logic vbc_addr_ok(input logic [7:0] a);
        return a == VBC_ADDR_CTRL || a == VBC_ADDR_BANK1
            || a == VBC_ADDR_BANK2 || a == VBC_ADDR_READBACK
            || a == VBC_ADDR_STATUS || a == VBC_ADDR_MASK
            || a == VBC_ADDR_SETTLE;
    endfunction : vbc_addr_ok

    function automatic logic [1:0] vbc_pick_osc(input logic [15:0] n);
        if (n < VCO_THRESH_LOW) begin
            return 2'h0;
        end else if (n < VCO_THRESH_HIGH) begin
            return 2'h1;
        end
        return 2'h2;
    endfunction : vbc_pick_osc

    function automatic logic vbc_band_bad(input logic [6:0] b);
        return b == VBC_BAND_MIN || b == VBC_BAND_MAX;
    endfunction : vbc_band_bad

    function automatic logic [2:0] vbc_clamp_div(input logic [2:0] d);
        if (d < VBC_LO_DIV_MIN) begin
            return VBC_LO_DIV_MIN;
        end else if (d > VBC_LO_DIV_MAX) begin
            return VBC_LO_DIV_MAX;
        end
        return d;
    endfunction : vbc_clamp_div

    vbc_band_search u_search (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (search_start),
        .step_tick (pd_tick),
        .settle    (r.settle),
        .above     (above),
        .trial     (search_trial),
        .band      (search_band),
        .done      (search_done)
    );

    always_comb begin
        next_r = r;
        // Pins pass three flops; only the second and third are read.
        next_r.s1 = {pd_ref_in, lock_detect_in, vco_above_in,
                     mixer_select_in, chip_enable_in};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        en       = r.s2[0];
        en_rise  = r.s2[0] & ~r.s3[0];
        mix_pin  = r.s2[1];
        above    = r.s2[2];
        lockd    = r.s2[3];
        pd_tick  = r.s2[4] & ~r.s3[4];
        mixsel   = r.sw_mode ? r.mix_sel_sw : mix_pin;
        active_n = mixsel ? r.synth_bank_second : r.synth_bank_first;

        // APB slave: answer in the first cycle of the access phase.
        setup      = psel & ~penable;
        access     = psel & penable & r.pready;
        relock_req = 1'b0;
        next_r.pready  = setup;
        next_r.pslverr = setup & ~vbc_addr_ok(paddr);
        next_r.prdata  = 32'h0000_0000;
        if (setup && !pwrite) begin
            unique case (paddr)
                VBC_ADDR_CTRL: next_r.prdata = 32'({r.lo_div,
                    r.full_duplex_select, r.mix_sel_sw, r.sw_mode, 1'b0});
                VBC_ADDR_BANK1:    next_r.prdata = 32'(r.synth_bank_first);
                VBC_ADDR_BANK2:    next_r.prdata = 32'(r.synth_bank_second);
                VBC_ADDR_READBACK: next_r.prdata = 32'(r.rb);
                VBC_ADDR_STATUS:   next_r.prdata = 32'(r.status);
                VBC_ADDR_MASK:     next_r.prdata = 32'(r.mask);
                VBC_ADDR_SETTLE:   next_r.prdata = 32'(r.settle);
                default:           next_r.prdata = 32'h0000_0000;
            endcase
        end
        if (access && pwrite) begin
            unique case (paddr)
                VBC_ADDR_CTRL: begin
                    relock_req = pwdata[VBC_CTRL_RELOCK];
                    next_r.sw_mode            = pwdata[VBC_CTRL_SW_MODE];
                    next_r.mix_sel_sw         = pwdata[VBC_CTRL_MIX_SEL];
                    next_r.full_duplex_select = pwdata[VBC_CTRL_FULLDUP];
                    next_r.lo_div = vbc_clamp_div(
                        pwdata[VBC_CTRL_LODIV_LO +: 3]);
                end
                VBC_ADDR_BANK1:  next_r.synth_bank_first  = pwdata[15:0];
                VBC_ADDR_BANK2:  next_r.synth_bank_second = pwdata[15:0];
                VBC_ADDR_MASK:   next_r.mask   = vbc_irq_type'(pwdata[2:0]);
                VBC_ADDR_SETTLE: next_r.settle = pwdata[7:0];
                default: ;
            endcase
        end

        // Calibration sequence.
        start        = en_rise | (relock_req & en);
        search_start = 1'b0;
        events       = '0;
        unique case (r.state)
            VBC_IDLE: ;
            VBC_SELECT: begin
                if (pd_tick) begin
                    next_r.state = VBC_SEARCH;
                    search_start = 1'b1;
                end
            end
            VBC_SEARCH: begin
                next_r.band_trim = search_trial;
                if (search_done) begin
                    next_r.state     = VBC_LOCK;
                    next_r.band_trim = search_band;
                    next_r.rb.band   = search_band;
                    next_r.rb.fail   = vbc_band_bad(search_band);
                    events.cal_done  = 1'b1;
                    events.cal_fail  = vbc_band_bad(search_band);
                end
            end
            VBC_LOCK: begin
                events.lock_gained = lockd & ~r.rb.lock;
            end
        endcase
        if (!en) begin
            next_r.state = VBC_IDLE;
        end else if (start) begin
            // Oscillator choice comes from the bank feeding this mixer.
            next_r.state    = VBC_SELECT;
            next_r.osc      = vbc_pick_osc(active_n);
            next_r.target_n = active_n;
            next_r.rb.osc   = vbc_pick_osc(active_n);
        end
        next_r.rb.busy = next_r.state == VBC_SELECT
                      || next_r.state == VBC_SEARCH;
        next_r.rb.lock = lockd && r.state == VBC_LOCK;
        next_r.loop_en = next_r.state == VBC_LOCK;

        // Full duplex overrides the selection and feeds both mixers.
        next_r.mix1 = en & (r.full_duplex_select | ~mixsel);
        next_r.mix2 = en & (r.full_duplex_select | mixsel);

        // Clear only bits that the read returned, so later events stay.
        if (access && !pwrite && paddr == VBC_ADDR_STATUS) begin
            next_r.status = r.status & ~vbc_irq_type'(r.prdata[2:0]);
        end
        next_r.status = next_r.status | events;
        next_r.irq    = |(next_r.status & next_r.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r                    <= '0;
            r.state              <= VBC_IDLE;
            r.lo_div             <= VBC_LO_DIV_RST;
            r.settle             <= VBC_SETTLE_RST;
            r.mask               <= VBC_MASK_RST;
            r.synth_bank_first   <= VBC_BANK_RST;
            r.synth_bank_second  <= VBC_BANK_RST;
        end else begin
            r <= next_r;
        end
    end

    assign prdata      = r.prdata;
    assign pready      = r.pready;
    assign pslverr     = r.pslverr;
    assign irq         = r.irq;
    assign osc_select  = r.osc;
    assign band_trim   = r.band_trim;
    assign target_n    = r.target_n;
    assign lo_div_code = r.lo_div;
    assign loop_enable = r.loop_en;
    assign mixer1_en   = r.mix1;
    assign mixer2_en   = r.mix2;

    property p_enable_start;
        @(posedge pclk) disable iff (!presetn)
        en_rise |=> r.state == VBC_SELECT && r.rb.busy;
    endproperty
    a_enable_start: assert property (p_enable_start)
        else $error("enable edge did not start calibration");

    property p_relock;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == VBC_ADDR_CTRL && pwdata[0] && en)
            |=> r.state == VBC_SELECT && r.rb.busy && !r.loop_en;
    endproperty
    a_relock: assert property (p_relock)
        else $error("re-lock write did not restart calibration");

    property p_pd_step;
        @(posedge pclk) disable iff (!presetn)
        (r.state == VBC_SELECT && en && !start && !pd_tick)
            |=> r.state == VBC_SELECT;
    endproperty
    a_pd_step: assert property (p_pd_step)
        else $error("calibration moved without a reference tick");

    property p_loop;
        @(posedge pclk) disable iff (!presetn)
        (r.state != VBC_LOCK) |-> ##1 (r.state == VBC_LOCK) == loop_enable;
    endproperty
    a_loop: assert property (p_loop)
        else $error("loop enabled outside the lock phase");

    property p_fail;
        @(posedge pclk) disable iff (!presetn)
        (r.state == VBC_SEARCH && search_done && en && !start
            && vbc_band_bad(search_band))
            |=> r.rb.fail && r.status.cal_fail && r.state == VBC_LOCK;
    endproperty
    a_fail: assert property (p_fail)
        else $error("extreme band code not flagged");

    property p_pass;
        @(posedge pclk) disable iff (!presetn)
        (r.state == VBC_SEARCH && search_done
            && !vbc_band_bad(search_band)) |=> !r.rb.fail;
    endproperty
    a_pass: assert property (p_pass)
        else $error("good band code flagged as failure");

    property p_band_read;
        @(posedge pclk) disable iff (!presetn)
        (r.state == VBC_SEARCH && search_done)
            |=> r.rb.band == $past(search_band);
    endproperty
    a_band_read: assert property (p_band_read)
        else $error("band code not stored for readback");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (r.state != VBC_SEARCH) |=> $stable(r.rb.band) && $stable(r.rb.fail);
    endproperty
    a_hold: assert property (p_hold)
        else $error("readback changed outside a completed search");

    property p_duplex;
        @(posedge pclk) disable iff (!presetn)
        (en && r.full_duplex_select) |=> mixer1_en && mixer2_en;
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("full duplex did not enable both mixers");

    property p_mix_pin;
        @(posedge pclk) disable iff (!presetn)
        (en && !r.full_duplex_select && !r.sw_mode)
            |=> mixer2_en == $past(mix_pin) && mixer1_en != mixer2_en;
    endproperty
    a_mix_pin: assert property (p_mix_pin)
        else $error("mixer routing does not follow the select pin");

    property p_lock_read;
        @(posedge pclk) disable iff (!presetn)
        (r.state != VBC_LOCK) |=> !r.rb.lock;
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock shown before calibration finished");

endmodule : vbc_top

// File: vbc_pkg.sv
package vbc_pkg;

    // Register byte offsets on the APB port.
    localparam logic [7:0] VBC_ADDR_CTRL     = 8'h00;
    localparam logic [7:0] VBC_ADDR_BANK1    = 8'h04;
    localparam logic [7:0] VBC_ADDR_BANK2    = 8'h08;
    localparam logic [7:0] VBC_ADDR_READBACK = 8'h0C;
    localparam logic [7:0] VBC_ADDR_STATUS   = 8'h10;
    localparam logic [7:0] VBC_ADDR_MASK     = 8'h14;
    localparam logic [7:0] VBC_ADDR_SETTLE   = 8'h18;

    // Control register field positions.
    localparam int VBC_CTRL_RELOCK   = 0;
    localparam int VBC_CTRL_SW_MODE  = 1;
    localparam int VBC_CTRL_MIX_SEL  = 2;
    localparam int VBC_CTRL_FULLDUP  = 3;
    localparam int VBC_CTRL_LODIV_LO = 4;

    // Values after reset.
    localparam logic [2:0]  VBC_LO_DIV_RST = 3'h1;
    localparam logic [7:0]  VBC_SETTLE_RST = 8'h04;
    localparam logic [2:0]  VBC_MASK_RST   = 3'h0;
    localparam logic [15:0] VBC_BANK_RST   = 16'h0000;

    // Divider code k selects a ratio of two to the power k.
    localparam logic [2:0] VBC_LO_DIV_MIN = 3'h1;
    localparam logic [2:0] VBC_LO_DIV_MAX = 3'h5;

    // Band code limits, search start code and top bit index; the two extremes flag a failed search.
    localparam logic [6:0] VBC_BAND_MIN   = 7'h00;
    localparam logic [6:0] VBC_BAND_MAX   = 7'h7F;
    localparam logic [6:0] VBC_BAND_START = 7'h40;
    localparam logic [2:0] VBC_BAND_TOP   = 3'h6;

    typedef enum logic [1:0] {
        VBC_IDLE   = 2'b00,
        VBC_SELECT = 2'b01,
        VBC_SEARCH = 2'b10,
        VBC_LOCK   = 2'b11
    } vbc_state_type;

    typedef enum logic {
        VBC_S_IDLE = 1'b0,
        VBC_S_WAIT = 1'b1
    } vbc_search_state_type;

    typedef struct packed {
        logic       busy;
        logic       lock;
        logic       fail;
        logic [1:0] osc;
        logic [6:0] band;
    } vbc_readback_type;

    typedef struct packed {
        logic lock_gained;
        logic cal_fail;
        logic cal_done;
    } vbc_irq_type;

endpackage : vbc_pkg

// File: vbc_band_search.sv
`timescale 1ns/100ps

module vbc_band_search
    import vbc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic       step_tick,
    input  wire logic [7:0] settle,
    input  wire logic       above,
    output logic [6:0]      trial,
    output logic [6:0]      band,
    output logic            done
);

    typedef struct packed {
        vbc_search_state_type st;
        logic [2:0]           idx;
        logic [6:0]           code;
        logic [7:0]           cnt;
        logic [6:0]           band;
        logic                 done;
    } vbc_search_reg_type;

    vbc_search_reg_type r;
    vbc_search_reg_type next_r;
    logic [6:0]         kept;

    function automatic logic [6:0] vbc_bit(input logic [2:0] i);
        return 7'(7'h01 << i);
    endfunction : vbc_bit

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        kept = r.code;
        // A fast oscillator keeps the trial element switched in.
        if (!above) begin
            kept = r.code & ~vbc_bit(r.idx);
        end
        if (start) begin
            next_r.st   = VBC_S_WAIT;
            next_r.idx  = VBC_BAND_TOP;
            next_r.code = VBC_BAND_START;
            next_r.cnt  = settle;
        end else if (r.st == VBC_S_WAIT && step_tick) begin
            if (r.cnt <= 8'h01) begin
                if (r.idx == 3'h0) begin
                    next_r.band = kept;
                    next_r.code = kept;
                    next_r.done = 1'b1;
                    next_r.st   = VBC_S_IDLE;
                end else begin
                    next_r.idx  = r.idx - 3'h1;
                    next_r.code = kept | vbc_bit(r.idx - 3'h1);
                    next_r.cnt  = settle;
                end
            end else begin
                next_r.cnt = r.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{VBC_S_IDLE, 3'h0, VBC_BAND_MIN, 8'h00, VBC_BAND_MIN, 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign trial = r.code;
    assign band  = r.band;
    assign done  = r.done;

    property p_step;
        @(posedge pclk) disable iff (!presetn)
        (!start && r.st == VBC_S_WAIT && step_tick && r.cnt <= 8'h01
            && r.idx != 3'h0) |=> r.code[r.idx] == 1'b1;
    endproperty
    a_step: assert property (p_step)
        else $error("next tuning element not switched in");

endmodule : vbc_band_search

// File: vbc_vco_model.sv
`timescale 1ns/100ps

module vbc_vco_model
    import vbc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [6:0] band_trim,
    input  wire logic       loop_enable,
    input  wire logic [7:0] goal,
    output logic            vco_above_in,
    output logic            lock_detect_in,
    output logic            pd_ref_in
);
    logic [3:0] settle_cnt;

    // More tuning elements slow the oscillator, so a code below the goal
    // leaves it running fast; a goal of 128 can never be reached.
    assign vco_above_in = ({1'b0, band_trim} < goal);

    // The reference runs free and has no phase relation to pclk.
    initial pd_ref_in = 1'b0;
    always #20.3 pd_ref_in = ~pd_ref_in;

    // The tuning voltage takes a while to enter the lock window.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= 4'h0;
        end else if (!loop_enable) begin
            settle_cnt <= 4'h0;
        end else if (settle_cnt != 4'hF) begin
            settle_cnt <= settle_cnt + 4'h1;
        end
    end
    assign lock_detect_in = (settle_cnt == 4'hF);
endmodule : vbc_vco_model

// File: tb_top.sv
`timescale 1ns/100ps

module tb_top;
    import vbc_pkg::*;
    localparam logic [15:0] THR_LO = 16'h0100;
    localparam logic [15:0] THR_HI = 16'h0200;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, goal;
    logic [31:0] pwdata, prdata, rd;
    logic        chip_enable_in, mixer_select_in, vco_above_in;
    logic        lock_detect_in, pd_ref_in, irq, loop_enable, le_q;
    logic        mixer1_en, mixer2_en, er, fl, sel;
    logic [1:0]  osc_select, eo;
    logic [6:0]  band_trim, trim_q, eb, prev_band;
    logic [15:0] target_n, act;
    logic [2:0]  lo_div_code;
    int          failures, comparisons;
    logic [15:0] t_b1 [5] = '{16'h0080, 16'h0180, 16'h0300, 16'h00FF,
                              16'h0100};
    logic [15:0] t_b2 [5] = '{16'h0300, 16'h0300, 16'h0080, 16'h0300,
                              16'h0200};
    logic [7:0]  t_ctl [5] = '{8'h10, 8'h11, 8'h11, 8'h11, 8'h17};
    logic [7:0]  t_goal [5] = '{8'h41, 8'h01, 8'h80, 8'h02, 8'h7F};
    logic [7:0]  m_ctl [5] = '{8'h12, 8'h16, 8'h1E, 8'h10, 8'h18};
    logic        m_pin [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

    vbc_top #(.VCO_THRESH_LOW(THR_LO), .VCO_THRESH_HIGH(THR_HI)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .chip_enable_in(chip_enable_in), .mixer_select_in(mixer_select_in),
        .vco_above_in(vco_above_in), .lock_detect_in(lock_detect_in),
        .pd_ref_in(pd_ref_in), .irq(irq), .osc_select(osc_select),
        .band_trim(band_trim), .target_n(target_n),
        .lo_div_code(lo_div_code), .loop_enable(loop_enable),
        .mixer1_en(mixer1_en), .mixer2_en(mixer2_en));

    vbc_vco_model i_vco (
        .pclk(pclk), .presetn(presetn), .band_trim(band_trim),
        .loop_enable(loop_enable), .goal(goal),
        .vco_above_in(vco_above_in), .lock_detect_in(lock_detect_in),
        .pd_ref_in(pd_ref_in));

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_lock;
        int n;
        n = 0;
        do begin
            apb(1'b0, VBC_ADDR_READBACK, 32'h0);
            n++;
        end while (rd[10] !== 1'b1 && n < 100);
        chk("lock bit", 32'h1, {31'h0, rd[10]});
    endtask : wait_lock

    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // Between relocks the band must stay put while the loop is closed.
    always @(posedge pclk) begin
        if (presetn && le_q && loop_enable && band_trim !== trim_q) begin
            failures++;
            $display("[FAIL] band_trim expected %h seen %h", trim_q,
                     band_trim);
        end
        trim_q <= band_trim;
        le_q   <= loop_enable;
    end

    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    initial begin
        {psel, penable, pwrite, chip_enable_in, mixer_select_in} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        goal = 8'h40;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk("lo div reset", VBC_LO_DIV_RST, lo_div_code);
        chk("mixers off", 32'h0, {mixer2_en, mixer1_en});
        apb(1'b0, VBC_ADDR_CTRL, 32'h0);
        chk("ctrl reset", {VBC_LO_DIV_RST, 4'h0}, rd);
        apb(1'b0, VBC_ADDR_SETTLE, 32'h0);
        chk("settle reset", VBC_SETTLE_RST, rd);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, VBC_ADDR_MASK, 32'h1);
        $display("Test reset done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, VBC_ADDR_BANK1, {16'h0, t_b1[i]});
            apb(1'b1, VBC_ADDR_BANK2, {16'h0, t_b2[i]});
            goal <= t_goal[i];
            act = t_ctl[i][2] ? t_b2[i] : t_b1[i];
            eb = (t_goal[i] == 8'h0) ? 7'h00 :
                 (t_goal[i] > 8'h80) ? 7'h7F : 7'(t_goal[i] - 8'h1);
            fl = (eb == VBC_BAND_MIN) || (eb == VBC_BAND_MAX);
            eo = (act < THR_LO) ? 2'd0 : (act < THR_HI) ? 2'd1 : 2'd2;
            // Mode bits settle first, so the restart picks the new bank.
            apb(1'b1, VBC_ADDR_CTRL, {24'h0, t_ctl[i] & 8'hFE});
            apb(1'b1, VBC_ADDR_CTRL, {24'h0, t_ctl[i]});
            if (i == 0) begin
                chip_enable_in <= 1'b1;
            end else begin
                apb(1'b0, VBC_ADDR_CTRL, 32'h0);
                chk("relock clear", {24'h0, t_ctl[i] & 8'hFE}, rd);
                apb(1'b0, VBC_ADDR_READBACK, 32'h0);
                chk("held band", prev_band, rd[6:0]);
            end
            for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge pclk);
            chk("irq done", 32'h1, {31'h0, irq});
            apb(1'b0, VBC_ADDR_STATUS, 32'h0);
            chk("status", {fl, 1'b1}, rd);
            apb(1'b0, VBC_ADDR_READBACK, 32'h0);
            chk("band", eb, rd[6:0]);
            chk("fail flag", fl, rd[9]);
            chk("osc", eo, rd[8:7]);
            chk("osc pin", eo, osc_select);
            chk("trim", eb, band_trim);
            chk("target", act, target_n);
            wait_lock();
            chk("loop on", 32'h1, {31'h0, loop_enable});
            apb(1'b0, VBC_ADDR_STATUS, 32'h0);
            chk("status lock", 32'h4, rd);
            prev_band = eb;
            $display("Test calibration %0d done", i);
        end
        apb(1'b1, VBC_ADDR_MASK, 32'h0);
        apb(1'b1, VBC_ADDR_CTRL, 32'h11);
        wait_lock();
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, VBC_ADDR_MASK, 32'h7);
        repeat (2) @(posedge pclk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(1'b0, VBC_ADDR_STATUS, 32'h0);
        chk("status both", 32'h5, rd);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("Test interrupt done");
        for (int i = 0; i < 5; i++) begin
            mixer_select_in <= m_pin[i];
            apb(1'b1, VBC_ADDR_CTRL, {24'h0, m_ctl[i]});
            repeat (4) @(posedge pclk);
            sel = m_ctl[i][1] ? m_ctl[i][2] : m_pin[i];
            chk("mixers", m_ctl[i][3] ? 2'b11 : {sel, ~sel},
                {mixer2_en, mixer1_en});
        end
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, VBC_ADDR_CTRL, {25'h0, 3'(k), 4'h2});
            repeat (3) @(posedge pclk);
            chk("lo div", (k < 1) ? 3'h1 : (k > 5) ? 3'h5 : 3'(k),
                lo_div_code);
        end
        $display("Test routing done");
        chip_enable_in <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("disabled", 32'h0, {loop_enable, mixer2_en, mixer1_en});
        $display("Test disable done");
        wrap_up();
    end
endmodule : tb_top
